// file: core/serial_uart.sv
// Asynchronous serial transceiver with FIFOs, flow control and infrared coding
`timescale 1ns/10ps
module serial_uart #(
   parameter int FIFO_DEPTH_P = uart_pkg::FIFO_DEPTH
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST_N,
   input wire uart_pkg::cfg_t I_CFG,
   input wire logic I_TX_VALID,
   input wire logic [uart_pkg::DATA_W-1:0] I_TX_DATA,
   output logic O_TX_READY,
   output logic O_RX_VALID,
   output logic [uart_pkg::DATA_W-1:0] O_RX_DATA,
   input wire logic I_RX_READY,
   output logic [$clog2(FIFO_DEPTH_P+1)-1:0] O_RX_LEVEL,
   input wire uart_pkg::flags_t I_FLAG_CLR,
   output uart_pkg::flags_t O_FLAGS,
   output logic O_TX_ENABLE,
   output logic O_TX_BUSY,
   input wire logic I_RXD,
   output logic O_TXD,
   input wire logic I_CTS,
   output logic O_RTS
);
   import uart_pkg::*;
   localparam int CW = $clog2(FIFO_DEPTH_P+1);

   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} st_t;

   // ****************************************
   // Shared configuration decode
   // ****************************************
   logic [15:0] div_ff;
   logic [15:0] div_min;
   logic [3:0] nbits;
   logic [DATA_W-1:0] len_mask;
   logic [17:0] pulse_len;

   assign div_min = I_CFG.sync_mode ? DIV_MIN_SYNC : DIV_MIN_ASYNC;

   // Out-of-range divisors are clamped rather than refused
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         div_ff <= DIV_MIN_ASYNC;
      end else begin
         div_ff <= (I_CFG.baud_divisor < div_min) ? div_min : I_CFG.baud_divisor;
      end
   end

   always_comb begin
      unique case (I_CFG.len)
         LEN_7: begin
            nbits = NBITS_7;
         end
         LEN_9: begin
            nbits = NBITS_9;
         end
         default: begin
            nbits = NBITS_8;
         end
      endcase
      len_mask = DATA_W'((18'h00001 << nbits) - 18'h00001);
   end

   always_comb begin
      if (I_CFG.ir_low_power) begin
         pulse_len = 18'({10'h000, I_CFG.infrared_prescaler} * 18'(IR_LP_MULT));
      end else begin
         pulse_len = 18'({2'h0, div_ff} * 18'(IR_PULSE_NUM)) >> IR_PULSE_SHIFT;
      end
   end

   // ****************************************
   // FIFOs
   // ****************************************
   logic tx_pop;
   logic tx_fifo_valid;
   logic [DATA_W-1:0] tx_fifo_data;
   logic rx_push;
   logic rx_fifo_ready;
   logic [DATA_W-1:0] rx_word;

   shift_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH_P)) u_tx_fifo (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(I_TX_VALID),
      .o_in_ready(O_TX_READY),
      .i_in_data(I_TX_DATA),
      .o_out_valid(tx_fifo_valid),
      .i_out_ready(tx_pop),
      .o_out_data(tx_fifo_data),
      .o_count()
   );

   shift_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH_P)) u_rx_fifo (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(rx_push),
      .o_in_ready(rx_fifo_ready),
      .i_in_data(rx_word),
      .o_out_valid(O_RX_VALID),
      .i_out_ready(I_RX_READY),
      .o_out_data(O_RX_DATA),
      .o_count(O_RX_LEVEL)
   );

   // ****************************************
   // Flow control
   // ****************************************
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         O_TX_ENABLE <= 1'b0;
      end else if (I_CFG.flow_ctrl_enable_bit) begin
         O_TX_ENABLE <= ~I_CTS;
      end else begin
         O_TX_ENABLE <= I_CFG.tx_enable_sw;
      end
   end

   // Between empty and the trigger level RTS keeps its last value
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || !I_CFG.flow_ctrl_enable_bit) begin
         O_RTS <= 1'b0;
      end else if (O_RX_LEVEL == '0) begin
         O_RTS <= 1'b0;
      end else if (O_RX_LEVEL >= CW'(I_CFG.rx_trigger_level)) begin
         O_RTS <= 1'b1;
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   st_t tx_st_ff;
   logic [15:0] tx_cnt_ff;
   logic [3:0] tx_idx_ff;
   logic tx_stop2_ff;
   logic [DATA_W-1:0] tx_sh_ff;
   logic tx_tick;
   logic tx_bit;
   logic [3:0] tx_pos;
   logic tx_par;

   assign tx_tick = (tx_cnt_ff == div_ff - 16'h0001);
   assign tx_pos = I_CFG.msb_first ? (nbits - 4'h1 - tx_idx_ff) : tx_idx_ff;
   assign tx_par = (^tx_sh_ff) ^ (I_CFG.parity == PAR_ODD);
   // A new character is taken only while enabled; one in flight runs on
   assign tx_pop = (tx_st_ff == S_IDLE) && tx_fifo_valid && O_TX_ENABLE;

   always_comb begin
      unique case (tx_st_ff)
         S_START: begin
            tx_bit = 1'b0;
         end
         S_DATA: begin
            tx_bit = tx_sh_ff[tx_pos];
         end
         S_PAR: begin
            tx_bit = tx_par;
         end
         default: begin
            tx_bit = 1'b1;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || tx_tick || tx_pop) begin
         tx_cnt_ff <= '0;
      end else begin
         tx_cnt_ff <= tx_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         tx_st_ff <= S_IDLE;
         tx_idx_ff <= '0;
         tx_stop2_ff <= 1'b0;
         tx_sh_ff <= '0;
      end else if (tx_pop) begin
         tx_st_ff <= S_START;
         tx_sh_ff <= tx_fifo_data & len_mask;
      end else if (tx_tick) begin
         unique case (tx_st_ff)
            S_IDLE: begin
               tx_st_ff <= S_IDLE;
            end
            S_START: begin
               tx_st_ff <= S_DATA;
               tx_idx_ff <= '0;
            end
            S_DATA: begin
               tx_idx_ff <= tx_idx_ff + 4'h1;
               if (tx_idx_ff == nbits - 4'h1) begin
                  tx_st_ff <= (I_CFG.parity == PAR_NONE) ? S_STOP : S_PAR;
                  tx_stop2_ff <= I_CFG.two_stop;
               end
            end
            S_PAR: begin
               tx_st_ff <= S_STOP;
            end
            S_STOP: begin
               tx_stop2_ff <= 1'b0;
               tx_st_ff <= tx_stop2_ff ? S_STOP : S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         O_TXD <= 1'b1;
         O_TX_BUSY <= 1'b0;
      end else begin
         O_TX_BUSY <= (tx_st_ff != S_IDLE) || tx_fifo_valid;
         if (I_CFG.ir_en) begin
            O_TXD <= ~tx_bit && ({2'h0, tx_cnt_ff} < pulse_len);
         end else begin
            O_TXD <= tx_bit;
         end
      end
   end

   // ****************************************
   // Infrared demodulator
   // ****************************************
   logic [8:0] flt_ff;
   logic [15:0] hold_ff;
   logic demod_ff;
   logic [8:0] flt_load;

   // Low power doubles the window: under one period is lost, over two is kept
   assign flt_load = I_CFG.ir_low_power ? {I_CFG.infrared_prescaler, 1'b0} : {1'b0, I_CFG.infrared_prescaler};

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || I_RXD) begin
         flt_ff <= flt_load;
      end else if (flt_ff != '0) begin
         flt_ff <= flt_ff - 9'h001;
      end
   end

   // An accepted pulse is stretched half a bit so the receiver can sample it
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         hold_ff <= '0;
         demod_ff <= 1'b1;
      end else begin
         if (!I_RXD && flt_ff == '0) begin
            hold_ff <= div_ff >> 1;
         end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 16'h0001;
         end
         demod_ff <= (hold_ff == '0);
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   st_t rx_st_ff;
   logic [15:0] rx_cnt_ff;
   logic [3:0] rx_idx_ff;
   logic [DATA_W-1:0] rx_sh_ff;
   logic rx_par_ff;
   logic rx_line;
   logic rx_tick;
   logic rx_half;
   logic [3:0] rx_pos;
   logic stop_seen;
   logic par_bad;
   flags_t flag_set;

   assign rx_line = I_CFG.ir_en ? demod_ff : I_RXD;
   assign rx_tick = (rx_cnt_ff == div_ff - 16'h0001);
   assign rx_half = (rx_cnt_ff == (div_ff >> 1) - 16'h0001);
   assign rx_pos = I_CFG.msb_first ? (nbits - 4'h1 - rx_idx_ff) : rx_idx_ff;
   assign stop_seen = (rx_st_ff == S_STOP) && rx_tick;
   assign par_bad = (I_CFG.parity != PAR_NONE) && (rx_par_ff != ((^rx_sh_ff) ^ (I_CFG.parity == PAR_ODD)));
   assign rx_word = rx_sh_ff;
   // Frames without a stop bit never enter the FIFO
   assign rx_push = stop_seen && rx_line && rx_fifo_ready;

   always_comb begin
      flag_set.parity_err = stop_seen && par_bad;
      flag_set.overrun = stop_seen && rx_line && !rx_fifo_ready;
      flag_set.frame_err = stop_seen && !rx_line;
      flag_set.brk = stop_seen && !rx_line && rx_sh_ff == '0 && !rx_par_ff;
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || (rx_st_ff == S_IDLE) || rx_tick || (rx_st_ff == S_START && rx_half)) begin
         rx_cnt_ff <= '0;
      end else begin
         rx_cnt_ff <= rx_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         rx_st_ff <= S_IDLE;
         rx_idx_ff <= '0;
         rx_sh_ff <= '0;
         rx_par_ff <= 1'b0;
      end else begin
         unique case (rx_st_ff)
            S_IDLE: begin
               if (!rx_line) begin
                  rx_st_ff <= S_START;
               end
            end
            S_START: begin
               if (rx_half) begin
                  rx_st_ff <= rx_line ? S_IDLE : S_DATA;
                  rx_idx_ff <= '0;
                  rx_sh_ff <= '0;
                  rx_par_ff <= 1'b0;
               end
            end
            S_DATA: begin
               if (rx_tick) begin
                  rx_sh_ff[rx_pos] <= rx_line;
                  rx_idx_ff <= rx_idx_ff + 4'h1;
                  if (rx_idx_ff == nbits - 4'h1) begin
                     rx_st_ff <= (I_CFG.parity == PAR_NONE) ? S_STOP : S_PAR;
                  end
               end
            end
            S_PAR: begin
               if (rx_tick) begin
                  rx_par_ff <= rx_line;
                  rx_st_ff <= S_STOP;
               end
            end
            S_STOP: begin
               if (rx_tick) begin
                  rx_st_ff <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         O_FLAGS <= '0;
      end else begin
         O_FLAGS <= (O_FLAGS & ~I_FLAG_CLR) | flag_set;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_rts_flow_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      !I_CFG.flow_ctrl_enable_bit |=> !O_RTS)
      else $error("RTS asserted with flow control off");
   a_rts_empty_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      I_CFG.flow_ctrl_enable_bit && O_RX_LEVEL == '0 |=> !O_RTS)
      else $error("RTS high while receive store empty");
   a_rts_trigger: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      I_CFG.flow_ctrl_enable_bit && O_RX_LEVEL != '0 && O_RX_LEVEL >= CW'(I_CFG.rx_trigger_level) |=> O_RTS)
      else $error("RTS low at trigger level");
   a_cts_txen: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      I_CFG.flow_ctrl_enable_bit |=> O_TX_ENABLE == !$past(I_CTS))
      else $error("Transmit enable does not follow CTS");
   a_tx_finish_char: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      tx_st_ff inside {S_START, S_DATA, S_PAR} |=> tx_st_ff != S_IDLE)
      else $error("Character cut short before stop bit");
   a_tx_hold_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      tx_st_ff == S_IDLE && !O_TX_ENABLE |=> tx_st_ff == S_IDLE)
      else $error("Character started while transmit disabled");
   a_start_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      tx_st_ff == S_START && !I_CFG.ir_en |=> !O_TXD)
      else $error("Start bit not at active level");
   a_stop_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      tx_st_ff inside {S_STOP, S_IDLE} && !I_CFG.ir_en |=> O_TXD)
      else $error("Stop or idle bit not at idle level");
   a_ir_idle_dark: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      tx_st_ff == S_IDLE && I_CFG.ir_en |=> !O_TXD)
      else $error("Infrared output lit for a one");
   a_overrun_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      stop_seen && rx_line && !rx_fifo_ready |-> !rx_push ##1 O_FLAGS.overrun)
      else $error("Overrun not flagged or character stored");
   a_frame_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      stop_seen && !rx_line |-> !rx_push ##1 O_FLAGS.frame_err)
      else $error("Missing stop bit not reported");
   a_div_floor: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      ##1 div_ff >= DIV_MIN_SYNC && (div_ff >= DIV_MIN_ASYNC || $past(I_CFG.sync_mode)))
      else $error("Baud divisor below its floor");
endmodule // serial_uart

// file: core/shift_fifo.sv
// Shift-register FIFO with registered head, count and handshake flags
`timescale 1ns/10ps
module shift_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH+1)-1:0] o_count
);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [CW-1:0] count_ff;
   logic [CW-1:0] nxt_count;
   logic [CW-1:0] wr_idx;
   logic push;
   logic pop;

   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;
   assign nxt_count = count_ff + CW'(push) - CW'(pop);
   assign wr_idx = count_ff - CW'(pop);
   assign o_out_data = mem_ff[0];
   assign o_count = count_ff;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_ff <= '0;
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         o_in_ready <= (nxt_count != CW'(DEPTH));
         o_out_valid <= (nxt_count != '0);
      end
   end

   // Entries move toward the head on a pop, so the head is always a register
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            mem_ff[i] <= '0;
         end else if (push && wr_idx == CW'(i)) begin
            mem_ff[i] <= i_in_data;
         end else if (pop) begin
            mem_ff[i] <= (i + 1 < DEPTH) ? mem_ff[(i + 1) % DEPTH] : '0;
         end
      end
   end
endmodule // shift_fifo

// file: core/uart_pkg.sv
// Shared constants, configuration and status types of the serial transceiver
package uart_pkg;
   // ****************************************
   // Sizes and limits
   // ****************************************
   localparam int DATA_W = 9;
   localparam int FIFO_DEPTH = 8;
   localparam logic [15:0] DIV_MIN_ASYNC = 16'h0010;
   localparam logic [15:0] DIV_MIN_SYNC = 16'h0008;
   localparam logic [3:0] NBITS_7 = 4'h7;
   localparam logic [3:0] NBITS_8 = 4'h8;
   localparam logic [3:0] NBITS_9 = 4'h9;
   // Infrared pulse: 3/16 of a bit, or 3 prescaler periods in low power
   localparam int IR_PULSE_NUM = 3;
   localparam int IR_PULSE_SHIFT = 4;
   localparam int IR_LP_MULT = 3;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {LEN_7, LEN_8, LEN_9} len_t;
   typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} par_t;

   typedef struct packed {
      logic [15:0] baud_divisor;
      len_t len;
      par_t parity;
      logic two_stop;
      logic msb_first;
      logic sync_mode;
      logic flow_ctrl_enable_bit;
      logic tx_enable_sw;
      logic [3:0] rx_trigger_level;
      logic ir_en;
      logic ir_low_power;
      logic [7:0] infrared_prescaler;
   } cfg_t;

   typedef struct packed {
      logic parity_err;
      logic overrun;
      logic frame_err;
      logic brk;
   } flags_t;
endpackage

// file: verif/serial_peer.sv
// Remote serial transceiver model: drives the receive line, decodes the transmit line while infrared is off
`timescale 1ns/10ps
module serial_peer (
   input wire logic i_clk,
   input wire uart_pkg::cfg_t i_cfg,
   input wire logic i_txd,
   output logic o_rxd
);
   import uart_pkg::*;
   logic [9:0] got_q[$];
   logic [8:0] w;
   logic ok;
   int n;

   function automatic int nbits(input len_t l);
      return (l == LEN_7) ? 7 : (l == LEN_9) ? 9 : 8;
   endfunction

   function automatic logic par_of(input logic [8:0] d);
      return (i_cfg.parity == PAR_ODD) ? ~^d : ^d;
   endfunction

   task automatic put(input logic v);
      @(posedge i_clk);
      o_rxd <= v;
      repeat (i_cfg.baud_divisor - 1) @(posedge i_clk);
   endtask

   // Faults are injected only on request: a flipped parity bit or a low stop bit
   task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
      int m;
      m = nbits(i_cfg.len);
      put(1'b0);
      for (int i = 0; i < m; i++) begin
         put(i_cfg.msb_first ? d[m-1-i] : d[i]);
      end
      if (i_cfg.parity != PAR_NONE) begin
         put(par_of(d & (9'h1FF >> (9 - m))) ^ bad_par);
      end
      put(~bad_stop);
      put(1'b1);
   endtask

   // Each decoded word carries a flag in bit 9: start, parity and stops all good
   initial begin
      o_rxd = 1'b1;
      forever begin
         @(negedge i_txd);
         if (!i_cfg.ir_en) begin
            n = nbits(i_cfg.len);
            w = '0;
            repeat (i_cfg.baud_divisor / 2) @(posedge i_clk);
            ok = ~i_txd;
            for (int i = 0; i < n; i++) begin
               repeat (i_cfg.baud_divisor) @(posedge i_clk);
               w[i_cfg.msb_first ? n-1-i : i] = i_txd;
            end
            if (i_cfg.parity != PAR_NONE) begin
               repeat (i_cfg.baud_divisor) @(posedge i_clk);
               ok &= (i_txd === par_of(w));
            end
            repeat (i_cfg.two_stop ? 2 : 1) begin
               repeat (i_cfg.baud_divisor) @(posedge i_clk);
               ok &= (i_txd === 1'b1);
            end
            got_q.push_back({ok, w});
         end
      end
   end
endmodule // serial_peer

// file: verif/serial_uart_flowctl_infrared_tb_top.sv
// Self-checking bench of the serial transceiver against the remote line model
`timescale 1ns/10ps
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module serial_uart_flowctl_infrared_tb_top;
   import uart_pkg::*;
   logic sys_clk, rst_n, tx_valid, tx_ready, rx_valid, rx_ready, tx_enable, tx_busy, rxd, txd, cts, rts, h;
   logic [8:0] tx_data, rx_data, d, v;
   logic [8:0] sent[9];
   logic [3:0] rx_level;
   logic [9:0] g;
   cfg_t cfg;
   flags_t flag_clr, flags;
   int fails, checks_done, cnt;

   serial_uart #(.FIFO_DEPTH_P(8)) DUT (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_CFG(cfg),
      .I_TX_VALID(tx_valid), .I_TX_DATA(tx_data), .O_TX_READY(tx_ready), .O_RX_VALID(rx_valid),
      .O_RX_DATA(rx_data), .I_RX_READY(rx_ready), .O_RX_LEVEL(rx_level), .I_FLAG_CLR(flag_clr),
      .O_FLAGS(flags), .O_TX_ENABLE(tx_enable), .O_TX_BUSY(tx_busy), .I_RXD(rxd), .O_TXD(txd),
      .I_CTS(cts), .O_RTS(rts));
   serial_peer peer (.i_clk(sys_clk), .i_cfg(cfg), .i_txd(txd), .o_rxd(rxd));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [8:0] masked(input logic [8:0] x);
      return x & (9'h1FF >> (4'h9 - ((cfg.len == LEN_7) ? NBITS_7 : (cfg.len == LEN_9) ? NBITS_9 : NBITS_8)));
   endfunction

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #2;
   endtask

   // Leaves valid high so two calls in a row give back-to-back writes
   task automatic put_tx(input logic [8:0] x);
      int t;
      t = 0;
      tx_valid = 1'b1;
      tx_data = x;
      do begin
         h = tx_ready;
         step(1);
         t++;
      end while (h !== 1'b1 && t < 50);
   endtask

   task automatic take_tx(output logic [9:0] x);
      int t;
      t = 0;
      while (peer.got_q.size() == 0 && t < 800) begin
         step(1);
         t++;
      end
      if (peer.got_q.size() > 0) begin
         x = peer.got_q.pop_front();
      end else begin
         x = 'x;
      end
   endtask

   task automatic take_rx(output logic [8:0] x);
      int t;
      t = 0;
      while (rx_valid !== 1'b1 && t < 400) begin
         step(1);
         t++;
      end
      x = (rx_valid === 1'b1) ? rx_data : 'x;
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Whole run is about 10k cycles; allow 60000 cycles, about six times that
   initial begin
      #(25 * 60000);
      fails++;
      print_verdict;
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      fails = 0;
      checks_done = 0;
      rst_n = 1'b0;
      tx_valid = 1'b0;
      tx_data = '0;
      rx_ready = 1'b0;
      flag_clr = '0;
      cts = 1'b0;
      cfg = '0;
      cfg.baud_divisor = 16'h0010;
      cfg.len = LEN_8;
      cfg.tx_enable_sw = 1'b1;
      cfg.infrared_prescaler = 8'h04;
      cfg.rx_trigger_level = 4'h2;
      d = 9'($urandom(32'h74FB));
      step(2);
      rst_n = 1'b1;
      `CHECK(txd, 1'b1)
      `CHECK(rts, 1'b0)
      step(2);
      $display("test reset done");
      for (int k = 0; k < 12; k++) begin
         step(20);
         cfg.len = len_t'(k % 3);
         cfg.parity = par_t'((k / 3) % 3);
         cfg.msb_first = k[0];
         cfg.two_stop = k[1];
         sent[0] = 9'($urandom);
         sent[1] = 9'($urandom);
         put_tx(sent[0]);
         put_tx(sent[1]);
         tx_valid = 1'b0;
         for (int j = 0; j < 2; j++) begin
            take_tx(g);
            `CHECK(g, {1'b1, masked(sent[j])})
         end
      end
      $display("test transmit formats done");
      step(40);
      for (int k = 0; k < 6; k++) begin
         cfg.len = len_t'(k % 3);
         cfg.parity = par_t'((k + 1) % 3);
         cfg.msb_first = k[0];
         d = 9'($urandom);
         peer.send(d, 1'b0, 1'b0);
         take_rx(v);
         `CHECK(v, masked(d))
      end
      cfg.parity = PAR_ODD;
      peer.send(d, 1'b1, 1'b0);
      take_rx(v);
      `CHECK(v, masked(d))
      `CHECK(flags.parity_err, 1'b1)
      flag_clr = '1;
      step(1);
      flag_clr = '0;
      step(1);
      `CHECK(flags, 4'h0)
      cfg.parity = PAR_EVEN;
      peer.send(9'h000, 1'b0, 1'b1);
      step(4);
      `CHECK(flags.frame_err, 1'b1)
      `CHECK(flags.brk, 1'b1)
      `CHECK(rx_level, 4'h0)
      $display("test receive errors done");
      cfg.flow_ctrl_enable_bit = 1'b1;
      step(3);
      `CHECK(rts, 1'b0)
      for (int k = 0; k < 9; k++) begin
         sent[k] = 9'($urandom);
         peer.send(sent[k], 1'b0, 1'b0);
         step(4);
         if (k < 2) begin
            `CHECK(rts, (k == 1))
         end
      end
      `CHECK(rx_level, 4'h8)
      `CHECK(flags.overrun, 1'b1)
      cfg.flow_ctrl_enable_bit = 1'b0;
      step(3);
      `CHECK(rts, 1'b0)
      cfg.flow_ctrl_enable_bit = 1'b1;
      step(3);
      `CHECK(rts, 1'b1)
      for (int k = 0; k < 8; k++) begin
         take_rx(v);
         `CHECK(v, masked(sent[k]))
      end
      step(2);
      `CHECK(rts, 1'b0)
      $display("test receive flow done");
      cts = 1'b1;
      step(3);
      `CHECK(tx_enable, 1'b0)
      d = 9'($urandom);
      put_tx(d);
      tx_valid = 1'b0;
      step(100);
      `CHECK(peer.got_q.size(), 0)
      `CHECK(tx_busy, 1'b1)
      cts = 1'b0;
      step(3);
      `CHECK(tx_enable, 1'b1)
      take_tx(g);
      `CHECK(g, {1'b1, masked(d)})
      step(20);
      put_tx(d);
      put_tx(~d);
      tx_valid = 1'b0;
      step(40);
      cts = 1'b1;
      take_tx(g);
      `CHECK(g, {1'b1, masked(d)})
      step(100);
      `CHECK(peer.got_q.size(), 0)
      cfg.flow_ctrl_enable_bit = 1'b0;
      step(3);
      `CHECK(tx_enable, 1'b1)
      take_tx(g);
      `CHECK(g, {1'b1, masked(~d)})
      step(20);
      `CHECK(tx_busy, 1'b0)
      $display("test clear to send done");
      step(40);
      cfg.ir_en = 1'b1;
      for (int m = 0; m < 2; m++) begin
         cfg.ir_low_power = m[0];
         step(2);
         put_tx(9'h000);
         tx_valid = 1'b0;
         cnt = 0;
         while (txd !== 1'b1 && cnt < 100) begin
            step(1);
            cnt++;
         end
         cnt = 0;
         while (txd === 1'b1 && cnt < 100) begin
            step(1);
            cnt++;
         end
         `CHECK(cnt, (m == 1) ? IR_LP_MULT * 4 : (IR_PULSE_NUM * 16) >> IR_PULSE_SHIFT)
         step(250);
      end
      // Receive only after our own pulses have long ended; the turnaround gap stands in for the long one
      d = 9'($urandom);
      peer.send(d, 1'b0, 1'b0);
      take_rx(v);
      `CHECK(v, masked(d))
      $display("test infrared pulses done");
      print_verdict;
   end
endmodule // serial_uart_flowctl_infrared_tb_top
